// *** rtl/pvm_regs.svh ***
// Register offsets, field positions, masks and reset values of the port control bank
`ifndef PVM_REGS_SVH
`define PVM_REGS_SVH
// Per-port register blocks: upper address nibble selects the port
`define PVM_PORT1_BASE 8'h10
`define PVM_PORT2_BASE 8'h20
`define PVM_PORT3_BASE 8'h30
`define PVM_BASE_MASK 8'hF0
// Register index inside a port block (lower address nibble)
`define PVM_IDX_QSPLIT 4'h0
`define PVM_IDX_MIRROR 4'h1
`define PVM_IDX_VLANQ 4'h2
`define PVM_IDX_TAGHI 4'h3
`define PVM_IDX_TAGLO 4'h4
// Full byte addresses of the VLAN/queue control registers
`define PVM_P1_VLANQ_OFF 8'h12
`define PVM_P2_VLANQ_OFF 8'h22
`define PVM_P3_VLANQ_OFF 8'h32
// Mirror/tag/membership control fields
`define PVM_MIR_RX 6
`define PVM_MIR_TX 5
`define PVM_MIR_DBL 4
`define PVM_MIR_CEIL 3
`define PVM_MIR_MEMB_HI 2
`define PVM_MIR_MEMB_LO 0
// VLAN/queue control fields
`define PVM_VQ_SPLIT2 7
`define PVM_VQ_FILT 6
`define PVM_VQ_VIDCHK 5
// Queue split control field
`define PVM_QS_SPLIT4 0
// VLAN table entry membership field
`define PVM_VT_MEMB_HI 18
`define PVM_VT_MEMB_LO 16
// Default tag fields
`define PVM_TAG_PRIO_HI 15
`define PVM_TAG_PRIO_LO 13
`define PVM_TAG_VID_HI 11
// Implemented bits of the mirror and VLAN/queue control registers
`define PVM_MIRROR_MASK 8'h7F
`define PVM_VLANQ_MASK 8'hE0
// Reset values
`define PVM_QSPLIT_RST 8'h00
`define PVM_MIRROR_RST 8'h07
`define PVM_VLANQ_RST 8'h00
`define PVM_TAGHI_RST 8'h00
`define PVM_TAGLO_RST 8'h01
`endif

// *** rtl/pvm_pkg.sv ***
// Types shared by the port VLAN and mirror control bank
package pvm_pkg;
   typedef logic [2:0] pvm_mask_t;
   typedef logic [1:0] pvm_port_t;
   typedef enum logic [1:0] {
      pvm_txq_one = 2'b00,
      pvm_txq_two = 2'b01,
      pvm_txq_four = 2'b11
   } pvm_txq_e;
endpackage

// *** rtl/pvm_port_regs.sv ***
// Control register set of one switch port
`timescale 1ns/1ps
`include "pvm_regs.svh"
module pvm_port_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register write from the decoder
   input wire logic wr_en,
   input wire logic [3:0] wr_idx,
   input wire logic [7:0] wr_data,
   // Stored fields
   output logic [7:0] qsplit,
   output logic [7:0] mirror,
   output logic [7:0] vlanq,
   output logic [15:0] def_tag
);
   // Queue split control
   always_ff @(posedge clk) begin
      if (rst) begin
         qsplit <= `PVM_QSPLIT_RST;
      end else if (wr_en && wr_idx == `PVM_IDX_QSPLIT) begin
         qsplit <= wr_data;
      end
   end

   // Mirror, tag and membership control; unimplemented bits stay zero
   always_ff @(posedge clk) begin
      if (rst) begin
         mirror <= `PVM_MIRROR_RST;
      end else if (wr_en && wr_idx == `PVM_IDX_MIRROR) begin
         mirror <= wr_data & `PVM_MIRROR_MASK;
      end
   end

   // VLAN filtering and two-queue control
   always_ff @(posedge clk) begin
      if (rst) begin
         vlanq <= `PVM_VLANQ_RST;
      end else if (wr_en && wr_idx == `PVM_IDX_VLANQ) begin
         vlanq <= wr_data & `PVM_VLANQ_MASK;
      end
   end

   // Default tag, written one byte at a time
   always_ff @(posedge clk) begin
      if (rst) begin
         def_tag <= {`PVM_TAGHI_RST, `PVM_TAGLO_RST};
      end else if (wr_en && wr_idx == `PVM_IDX_TAGHI) begin
         def_tag[15:8] <= wr_data;
      end else if (wr_en && wr_idx == `PVM_IDX_TAGLO) begin
         def_tag[7:0] <= wr_data;
      end
   end
endmodule

// *** rtl/pvm_prio_ceiling.sv ***
// User priority ceiling against the port default tag
`timescale 1ns/1ps
module pvm_prio_ceiling (
   // Control
   input wire logic enable,
   // Priorities
   input wire logic [2:0] pkt_prio,
   input wire logic [2:0] ceil_prio,
   output logic [2:0] out_prio
);
   // No comparison at all when disabled
   always_comb begin
      out_prio = pkt_prio;
      if (enable && pkt_prio > ceil_prio) begin
         out_prio = ceil_prio;
      end
   end
endmodule

// *** rtl/pvm_port_ctrl.sv ***
// Port VLAN, mirror and queue control bank with its per-frame decision stage
`timescale 1ns/1ps
`include "pvm_regs.svh"

module pvm_port_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   output logic [7:0] rd_data,
   // Frame decision request
   input wire logic in_valid,
   input wire logic [1:0] in_port,
   input wire logic [11:0] in_vid,
   input wire logic [2:0] in_prio,
   input wire logic [18:0] in_vt_entry,
   input wire logic [2:0] in_dest,
   input wire logic [2:0] sniffer_mask,
   // Frame decision result
   output logic out_valid,
   output logic out_drop,
   output logic [2:0] out_dest,
   output logic out_monitored,
   output logic out_add_tag,
   output logic [15:0] out_tag,
   output logic [2:0] out_prio,
   // Transmit queue arrangement, two bits per port
   output logic [5:0] txq_mode
);
   // ****************************************************************
   // Address decode
   // ****************************************************************

   // Port index of an address, 3 when no port block matches
   function automatic pvm_pkg::pvm_port_t addr_port(input logic [7:0] a);
      pvm_pkg::pvm_port_t p;
      p = 2'd3;
      if ((a & `PVM_BASE_MASK) == `PVM_PORT1_BASE) begin
         p = 2'd0;
      end else if ((a & `PVM_BASE_MASK) == `PVM_PORT2_BASE) begin
         p = 2'd1;
      end else if ((a & `PVM_BASE_MASK) == `PVM_PORT3_BASE) begin
         p = 2'd2;
      end
      return p;
   endfunction

   logic [7:0] qsplit [3];
   logic [7:0] mirror [3];
   logic [7:0] vlanq [3];
   logic [15:0] def_tag [3];
   logic [2:0] tx_sniff_vec;
   pvm_pkg::pvm_port_t wr_port;
   pvm_pkg::pvm_port_t rd_port;

   assign wr_port = addr_port(addr);
   assign rd_port = addr_port(addr);

   // ****************************************************************
   // Per-port register sets
   // ****************************************************************

   // Identical layout in every port block; only the upper nibble differs
   for (genvar g = 0; g < 3; g++) begin : g_port
      pvm_port_regs u_regs (
         .clk(clk),
         .rst(rst),
         .wr_en(wr_strobe && wr_port == 2'(g)),
         .wr_idx(addr[3:0]),
         .wr_data(wr_data),
         .qsplit(qsplit[g]),
         .mirror(mirror[g]),
         .vlanq(vlanq[g]),
         .def_tag(def_tag[g])
      );
      assign tx_sniff_vec[g] = mirror[g][`PVM_MIR_TX];
   end

   // ****************************************************************
   // Register read
   // ****************************************************************

   logic [7:0] next_rd_data;

   // Unmapped addresses read as zero
   always_comb begin
      next_rd_data = 8'h00;
      if (rd_port != 2'd3) begin
         if (addr[3:0] == `PVM_IDX_QSPLIT) begin
            next_rd_data = qsplit[rd_port];
         end else if (addr[3:0] == `PVM_IDX_MIRROR) begin
            next_rd_data = mirror[rd_port];
         end else if (addr[3:0] == `PVM_IDX_VLANQ) begin
            next_rd_data = vlanq[rd_port];
         end else if (addr[3:0] == `PVM_IDX_TAGHI) begin
            next_rd_data = def_tag[rd_port][15:8];
         end else if (addr[3:0] == `PVM_IDX_TAGLO) begin
            next_rd_data = def_tag[rd_port][7:0];
         end
      end
   end

   // Data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= rd_strobe ? next_rd_data : 8'h00;
      end
   end

   // ****************************************************************
   // Frame decision, combinational part
   // ****************************************************************

   logic port_ok;
   pvm_pkg::pvm_port_t ip;
   pvm_pkg::pvm_mask_t ing_onehot;
   pvm_pkg::pvm_mask_t memb_c;
   pvm_pkg::pvm_mask_t normal_c;
   logic rx_hit;
   logic tx_hit;
   logic filt_drop;
   logic vid_drop;
   logic drop_c;
   logic mon_c;
   logic [2:0] prio_c;

   // An unknown ingress port selects port 1 fields but the frame is dropped
   assign port_ok = in_port < 2'd3;
   assign ip = port_ok ? in_port : 2'd0;
   assign ing_onehot = port_ok ? (3'b001 << in_port) : 3'b000;

   // Egress membership of the ingress port limits the normal destinations
   assign memb_c = mirror[ip][`PVM_MIR_MEMB_HI:`PVM_MIR_MEMB_LO];
   assign normal_c = in_dest & memb_c;

   // Mirroring triggers on the ingress port or any egress port
   assign rx_hit = mirror[ip][`PVM_MIR_RX];
   assign tx_hit = |(normal_c & tx_sniff_vec);

   // Ingress filtering against the VLAN table membership field
   assign filt_drop = vlanq[ip][`PVM_VQ_FILT]
      && ((in_vt_entry[`PVM_VT_MEMB_HI:`PVM_VT_MEMB_LO] & ing_onehot) == 3'b000);
   assign vid_drop = vlanq[ip][`PVM_VQ_VIDCHK]
      && (in_vid != def_tag[ip][`PVM_TAG_VID_HI:0]);
   assign drop_c = !port_ok || filt_drop || vid_drop;
   assign mon_c = !drop_c && (rx_hit || tx_hit);

   // Priority ceiling against the default tag priority
   pvm_prio_ceiling u_ceil (
      .enable(mirror[ip][`PVM_MIR_CEIL]),
      .pkt_prio(in_prio),
      .ceil_prio(def_tag[ip][`PVM_TAG_PRIO_HI:`PVM_TAG_PRIO_LO]),
      .out_prio(prio_c)
   );

   // ****************************************************************
   // Frame decision, registered result
   // ****************************************************************

   // Valid follows the request one cycle later
   always_ff @(posedge clk) begin
      if (rst) begin
         out_valid <= 1'b0;
      end else begin
         out_valid <= in_valid;
      end
   end

   // Destinations: sniffer is added on top, never in place of the others
   always_ff @(posedge clk) begin
      if (rst) begin
         out_drop <= 1'b0;
         out_dest <= 3'b000;
         out_monitored <= 1'b0;
      end else if (in_valid) begin
         out_drop <= drop_c;
         out_dest <= drop_c ? 3'b000 : (normal_c | (mon_c ? sniffer_mask : 3'b000));
         out_monitored <= mon_c;
      end
   end

   // Tagging and priority; held between frames
   always_ff @(posedge clk) begin
      if (rst) begin
         out_add_tag <= 1'b0;
         out_tag <= 16'h0000;
         out_prio <= 3'b000;
      end else if (in_valid) begin
         out_add_tag <= !drop_c && mirror[ip][`PVM_MIR_DBL];
         out_tag <= def_tag[ip];
         out_prio <= prio_c;
      end
   end

   // ****************************************************************
   // Transmit queue arrangement
   // ****************************************************************

   // Four-queue wins if software breaks the exclusion, so the mode stays defined
   always_ff @(posedge clk) begin
      if (rst) begin
         txq_mode <= {3{pvm_pkg::pvm_txq_one}};
      end else begin
         for (int k = 0; k < 3; k++) begin
            if (qsplit[k][`PVM_QS_SPLIT4]) begin
               txq_mode[2*k +: 2] <= pvm_pkg::pvm_txq_four;
            end else if (vlanq[k][`PVM_VQ_SPLIT2]) begin
               txq_mode[2*k +: 2] <= pvm_pkg::pvm_txq_two;
            end else begin
               txq_mode[2*k +: 2] <= pvm_pkg::pvm_txq_one;
            end
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence wr_p1_vlanq;
      wr_strobe && addr == `PVM_P1_VLANQ_OFF;
   endsequence

   sequence rd_p1_vlanq;
      rd_strobe && addr == `PVM_P1_VLANQ_OFF;
   endsequence

   // Receive mirroring sends the frame to every sniffer port
   rx_mirror_a: assert property (
      in_valid && !drop_c && rx_hit |=> out_monitored
         && ((out_dest & $past(sniffer_mask)) == $past(sniffer_mask)))
      else $error("receive mirror not applied");

   // Transmit mirroring seen on any egress destination
   tx_mirror_a: assert property (
      in_valid && !drop_c && |(in_dest & memb_c & tx_sniff_vec) |=> out_monitored)
      else $error("transmit mirror not applied");

   // Double tag follows the ingress port setting
   dbl_tag_a: assert property (
      in_valid && !drop_c |=> out_add_tag == $past(mirror[ip][`PVM_MIR_DBL])
         && out_tag == $past(def_tag[ip]))
      else $error("double tag decision wrong");

   // Ceiling replaces a higher priority, otherwise priority passes
   ceiling_a: assert property (
      in_valid |=> out_prio == (($past(mirror[ip][`PVM_MIR_CEIL])
         && $past(in_prio) > $past(def_tag[ip][15:13]))
         ? $past(def_tag[ip][15:13]) : $past(in_prio)))
      else $error("priority ceiling wrong");

   // Membership defaults to all ports after reset
   memb_reset_a: assert property (
      $fell(rst) |-> memb_c == 3'b111 && mirror[1][2:0] == 3'b111 && mirror[2][2:0] == 3'b111)
      else $error("membership reset value wrong");

   // Without mirroring only member destinations remain
   memb_dest_a: assert property (
      in_valid && !drop_c && !mon_c |=> out_dest == $past(in_dest & memb_c))
      else $error("egress membership not applied");

   // Ingress filtering drops frames of non-member ports
   vlan_filt_a: assert property (
      in_valid && port_ok && vlanq[in_port][`PVM_VQ_FILT]
         && !in_vt_entry[`PVM_VT_MEMB_LO + 32'(in_port)] |=> out_valid && out_drop
         && out_dest == 3'b000 && !out_monitored)
      else $error("ingress filter did not drop");

   // Non-default VID drop, and no drop when both checks are off
   vid_discard_a: assert property (
      in_valid && port_ok && !vlanq[in_port][`PVM_VQ_FILT] |=> out_drop ==
         ($past(vlanq[ip][`PVM_VQ_VIDCHK]) && $past(in_vid) != $past(def_tag[ip][11:0])))
      else $error("default VID discard wrong");

   // Written VLAN control byte reads back two cycles later
   vlanq_rdback_a: assert property (
      wr_p1_vlanq ##1 rd_p1_vlanq |=> rd_data == ($past(wr_data, 2) & `PVM_VLANQ_MASK))
      else $error("VLAN control readback wrong");

   // Mirroring never removes a normal destination
   mirror_keep_a: assert property (
      in_valid && !drop_c |=> (out_dest & $past(normal_c)) == $past(normal_c))
      else $error("mirror removed a destination");
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the port VLAN, mirror and queue control bank
`timescale 1ns/1ps
`include "pvm_regs.svh"
module tb_top;
   // ****************
   // Signals
   // ****************
   logic clk, rst, wr_strobe, rd_strobe, in_valid;
   logic [7:0] addr, wr_data, rd_data;
   logic [1:0] in_port;
   logic [11:0] in_vid;
   logic [2:0] in_prio, in_dest, sniffer_mask, out_dest, out_prio;
   logic [18:0] in_vt_entry;
   logic out_valid, out_drop, out_monitored, out_add_tag;
   logic [15:0] out_tag;
   logic [5:0] txq_mode;
   integer seed = 32'ha17b;
   integer failures = 0;
   integer samples_checked = 0;
   // Shadow of every register, already masked to its implemented bits
   logic [7:0] sh [3][5];
   logic [7:0] rv;
   pvm_port_ctrl pvm_port_ctrl_inst (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
      .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .in_valid(in_valid),
      .in_port(in_port), .in_vid(in_vid), .in_prio(in_prio), .in_vt_entry(in_vt_entry),
      .in_dest(in_dest), .sniffer_mask(sniffer_mask), .out_valid(out_valid),
      .out_drop(out_drop), .out_dest(out_dest), .out_monitored(out_monitored),
      .out_add_tag(out_add_tag), .out_tag(out_tag), .out_prio(out_prio), .txq_mode(txq_mode));
   // Free-running clock, 5 ns period
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ****************
   // Helpers
   // ****************
   function automatic logic [7:0] msk(input int i);
      return (i == 1) ? `PVM_MIRROR_MASK : (i == 2) ? `PVM_VLANQ_MASK : 8'hFF;
   endfunction
   // Queue arrangement; stimulus never sets both splits, so the order here is moot
   function automatic logic [5:0] txq_exp();
      logic [5:0] t;
      for (int p = 0; p < 3; p++) begin
         t[2*p +: 2] = sh[p][0][0] ? 2'b11 : sh[p][2][7] ? 2'b01 : 2'b00;
      end
      return t;
   endfunction
   // Expected decision: drop, dest, monitored, add_tag, tag, prio
   function automatic logic [24:0] model(input logic [1:0] p, input logic [11:0] vid,
         input logic [2:0] prio, input logic [18:0] vte, input logic [2:0] dest,
         input logic [2:0] snif);
      logic [1:0] q;
      logic [2:0] nrm, d, pr;
      logic [15:0] t;
      logic drop, txs, mon;
      q = (p == 2'd3) ? 2'd0 : p;
      t = {sh[q][3], sh[q][4]};
      nrm = dest & sh[q][1][2:0];
      drop = (p == 2'd3) | (sh[q][2][6] & !vte[16 + q]) | (sh[q][2][5] & (vid != t[11:0]));
      txs = 1'b0;
      for (int j = 0; j < 3; j++) begin
         if (nrm[j] && sh[j][1][5]) txs = 1'b1;
      end
      mon = !drop & (sh[q][1][6] | txs);
      d = drop ? 3'h0 : (nrm | (mon ? snif : 3'h0));
      pr = (sh[q][1][3] && prio > t[15:13]) ? t[15:13] : prio;
      return {drop, d, mon, !drop & sh[q][1][4], t, pr};
   endfunction
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ****************
   // Bus tasks
   // ****************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_strobe <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_strobe <= 1'b0;
      if (a[7:4] >= 4'h1 && a[7:4] <= 4'h3 && a[3:0] <= 4'h4) begin
         sh[a[7:4]-1][a[3:0]] = d & msk(a[3:0]);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd_strobe <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_strobe <= 1'b0;
      #1;
      chk("rd_data", exp, rd_data);
   endtask
   // Write then read one mapped register with no gap between the two strobes
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_strobe <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b1;
      sh[a[7:4]-1][a[3:0]] = d & msk(a[3:0]);
      @(posedge clk);
      rd_strobe <= 1'b0;
      #1;
      chk("rd_data b2b", sh[a[7:4]-1][a[3:0]], rd_data);
   endtask
   task automatic chk_regs();
      for (int p = 0; p < 3; p++) begin
         for (int i = 0; i < 5; i++) rd({p[3:0] + 4'h1, i[3:0]}, sh[p][i]);
      end
      chk("txq_mode", txq_exp(), txq_mode);
   endtask
   task automatic do_reset(input int n);
      @(posedge clk);
      rst <= 1'b1;
      repeat (n) @(posedge clk);
      rst <= 1'b0;
      for (int p = 0; p < 3; p++) begin
         sh[p] = '{`PVM_QSPLIT_RST, `PVM_MIRROR_RST, `PVM_VLANQ_RST,
            `PVM_TAGHI_RST, `PVM_TAGLO_RST};
      end
   endtask
   // Random setup that never sets both queue splits of one port
   task automatic rnd_cfg(input logic quiet);
      logic [7:0] q, v;
      for (int p = 0; p < 3; p++) begin
         q = $random(seed);
         v = $random(seed);
         wr({p[3:0] + 4'h1, 4'h1}, quiet ? (v & 8'h07) : v);
         v = $random(seed);
         if (q[0] || quiet) v[7] = 1'b0;
         if (quiet) v = 8'h00;
         // Order the writes so both splits are never on at once, even between writes
         if (q[0]) begin
            wr({p[3:0] + 4'h1, 4'h2}, v);
            wr({p[3:0] + 4'h1, 4'h0}, q);
         end else begin
            wr({p[3:0] + 4'h1, 4'h0}, q);
            wr({p[3:0] + 4'h1, 4'h2}, v);
         end
         wr({p[3:0] + 4'h1, 4'h3}, $random(seed));
         wr({p[3:0] + 4'h1, 4'h4}, $random(seed));
      end
   endtask
   // Back-to-back decisions, each checked one cycle after it was taken
   task automatic frames(input int n);
      logic [24:0] e, seen;
      logic bad, nbad;
      logic [1:0] p;
      logic [11:0] v;
      for (int k = 0; k <= n; k++) begin
         @(posedge clk);
         if (k < n) begin
            p = $random(seed);
            v = $random(seed);
            if ($random(seed) & 1) v = {sh[p == 2'd3 ? 0 : p][3][3:0], sh[p == 2'd3 ? 0 : p][4]};
            in_valid <= 1'b1;
            in_port <= p;
            in_vid <= v;
            in_prio <= $random(seed);
            in_vt_entry <= $random(seed);
            in_dest <= $random(seed);
            sniffer_mask <= $random(seed);
            nbad = (p == 2'd3);
         end else begin
            in_valid <= 1'b0;
         end
         #1;
         seen = {out_drop, out_dest, out_monitored, out_add_tag, out_tag, out_prio};
         if (k > 0) begin
            chk("out_valid", 1, out_valid);
            if (bad) chk("decision", e[24:19], seen[24:19]);
            else chk("decision", e, seen);
         end
         if (k < n) e = model(p, v, in_prio, in_vt_entry, in_dest, sniffer_mask);
         bad = nbad;
      end
      @(posedge clk);
      #1;
      seen = {out_drop, out_dest, out_monitored, out_add_tag, out_tag, out_prio};
      chk("out_valid idle", 0, out_valid);
      if (!bad) chk("held", e, seen);
   endtask
   // ****************
   // Main sequence
   // ****************
   initial begin
      rst = 1'b1;
      {wr_strobe, rd_strobe, in_valid, addr, wr_data} = '0;
      {in_port, in_vid, in_prio, in_vt_entry, in_dest, sniffer_mask} = '0;
      do_reset(5);
      #1;
      chk("out_valid reset", 0, out_valid);
      chk_regs();
      rd(8'h05, 8'h00);
      rd(8'h40, 8'h00);
      @(posedge clk);
      #1;
      chk("rd_data after", 0, rd_data);
      $display("Test reset values done");
      for (int r = 0; r < 4; r++) begin
         rnd_cfg(1'b0);
         wr(8'h45, $random(seed));
         rv = $random(seed);
         if (sh[0][0][0]) rv[7] = 1'b0;
         wr_rd(`PVM_P1_VLANQ_OFF, rv);
         chk_regs();
         rd(8'h45, 8'h00);
      end
      $display("Test register access done");
      for (int c = 0; c < 3; c++) begin
         for (int p = 0; p < 3; p++) begin
            // Two-queue split goes off before the four-queue split goes on
            wr({p[3:0] + 4'h1, 4'h2}, (c == 1) ? 8'h80 : 8'h00);
            wr({p[3:0] + 4'h1, 4'h0}, (c == 2) ? 8'h01 : 8'h00);
         end
         // Queue mode follows the last write one cycle later
         @(posedge clk);
         #1;
         chk("txq_mode", txq_exp(), txq_mode);
      end
      $display("Test queue split done");
      for (int r = 0; r < 8; r++) begin
         rnd_cfg(r == 0);
         frames(60);
      end
      $display("Test frame decisions done");
      do_reset(2);
      chk_regs();
      frames(20);
      $display("Test second reset done");
      end_sim();
   end
   // Watchdog well beyond the expected run of about eleven hundred and forty cycles
   initial begin
      #200000;
      failures++;
      end_sim();
   end
endmodule
